//--- core/test_loop_defs.vh
// Constants shared by the test loop command decoder and its field decoder.
`ifndef TEST_LOOP_DEFS_VH
`define TEST_LOOP_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_MSG_LEN 8'h04
`define OFS_MSG_DATA 8'h08
`define OFS_LOOP_STAT 8'h0c
`define OFS_ACK 8'h10
`define OFS_DISCARD_CNT 8'h14

// ----------------------------------------------------------------------
// Register fields and reset values
// ----------------------------------------------------------------------
`define CTRL_DECODE_EN 0
`define CTRL_CONSOLE_READY 1
`define CTRL_RESET 2'h1
`define ACK_VALID_BIT 31
`define ACK_HAS_RESULT_BIT 16

// ----------------------------------------------------------------------
// Message header and message type codes
// ----------------------------------------------------------------------
`define PROTO_TEST 4'hf
`define SKIP_NONE 4'h0
`define NIBBLE_3G_RESERVED 4'h4
`define MT_CLOSE_TRAFFIC 8'h00
`define MT_CLOSE_TRAFFIC_ACK 8'h01
`define MT_OPEN_LOOP 8'h06
`define MT_CONSOLE_ACT 8'h0c
`define MT_CONSOLE_ACT_ACK 8'h0d
`define MT_CONSOLE_DEACT 8'h10
`define MT_AUDIO_TEST 8'h14
`define MT_CLOSE_MULTI 8'h20
`define MT_CLOSE_MULTI_ACK 8'h21
`define MT_OPEN_MULTI 8'h22
`define MT_OPEN_MULTI_ACK 8'h23
`define OPEN_ACK_IEI 4'h8
`define OPEN_ACK_VALUE 4'h1

// ----------------------------------------------------------------------
// Loop types and field codes
// ----------------------------------------------------------------------
`define LOOP_NONE 4'h0
`define LOOP_A 4'h1
`define LOOP_B 4'h2
`define LOOP_C 4'h3
`define LOOP_D 4'h4
`define LOOP_E 4'h5
`define LOOP_F 4'h6
`define LOOP_G 4'h7
`define LOOP_H 4'h8
`define CODING_NONE 2'h0
`define CODING_NEEDED 2'h1
`define MECH_ONE 3'h0
`define MECH_TWO 3'h1
`define AUDIO_NORMAL 3'h0
`define AUDIO_DECODER 3'h1
`define AUDIO_ENCODER 3'h2
`define AUDIO_ACOUSTIC 3'h4

`endif

//--- core/loop_field_decode.v
// Field decoder for the loop type octets of the two close commands.
`include "test_loop_defs.vh"

module loop_field_decode (
   // Sub-channel octet of the close traffic loop command
   input wire [7:0] subch_octet,
   // Loop type octet of the close multi-slot loop command
   input wire [7:0] multi_octet,
   // Traffic loop decode
   output reg [3:0] traffic_type,
   output wire traffic_subch,
   // Multi-slot loop decode
   output wire multi_ok,
   output reg [3:0] multi_type,
   output wire [1:0] multi_coding,
   output wire [2:0] multi_mech,
   output wire [2:0] multi_slot
);

   // ----------------------------------------------------------------------
   // Traffic loop
   // ----------------------------------------------------------------------

   // Spare bits 8 to 6 are ignored on receipt.
   assign traffic_subch = subch_octet[0];

   // Bits 5 and 4 take priority, then bit 3, then bit 2.
   always @* begin
      case (subch_octet[4:3])
         2'b01: traffic_type = `LOOP_D;
         2'b10: traffic_type = `LOOP_E;
         2'b11: traffic_type = `LOOP_F;
         default: begin
            if (subch_octet[2]) begin
               traffic_type = `LOOP_C;
            end else if (subch_octet[1]) begin
               traffic_type = `LOOP_B;
            end else begin
               traffic_type = `LOOP_A;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Multi-slot loop
   // ----------------------------------------------------------------------

   // Field placement is slot, then mechanism, then coding.
   assign multi_slot = multi_octet[7:5];
   assign multi_mech = multi_octet[4:2];
   assign multi_coding = multi_octet[1:0];

   // Reserved coding or mechanism values make the command unrecognised.
   assign multi_ok = (multi_coding == `CODING_NONE ||
                      multi_coding == `CODING_NEEDED) &&
                     (multi_mech == `MECH_ONE ||
                      multi_mech == `MECH_TWO);

   // Coding field selects between the two multi-slot loop types.
   always @* begin
      case (multi_coding)
         `CODING_NONE: multi_type = `LOOP_G;
         `CODING_NEEDED: multi_type = `LOOP_H;
         default: multi_type = `LOOP_NONE;
      endcase
   end

endmodule

//--- core/test_loop_command_decoder.v
// Test loop command decoder: APB slave, message decode and loop control.
//
// Overview of operation
// - Messages with a nonzero skip indicator are dropped without any answer.
// - Every test message carries protocol discriminator 1111.
// - Type nibbles 0000, 0001, 0010 are legacy; 0100 is never decoded.
// - Close loop is 00, open loop 06, close multi-slot loop 20.
// - Close traffic loop is answered with acknowledgement type 01, no fields.
// - Sub-channel bit 1 set selects half-rate sub-channel 1.
// - With bits 5..3 clear, bit 2 picks loop type A or B.
// - Bit 3 set with bits 5,4 clear gives loop type C, bit 2 ignored.
// - Bit 4 set, bit 5 clear gives loop type D.
// - Bit 5 set, bit 4 clear gives loop type E.
// - Bits 5 and 4 set give loop type F.
// - With bits 5,4 clear, bits 3 and 2 decide; bits 8..6 are spare.
// - Open loop may carry one octet: identifier 1000, value 0001.
// - Coding field 00 gives loop G, 01 loop H, others reserved.
// - Mechanism field 000 is mechanism 1, 001 mechanism 2.
// - Timeslot number is used only with mechanism 1.
// - Console link activates only with test card, on power, insert, command.
// - Once active and ready, exactly one flow-resume message is sent.
// - Console deactivates on power off, removal, command; no flow-stop.
// - Console activate is acknowledged; console deactivate is not.
// - Each new audio test function replaces the previous one.
// - Multi-slot close answered with type 21 and a result octet.
// - Console activate is 0c, its ack 0d, console deactivate 10.
`include "test_loop_defs.vh"

module test_loop_command_decoder (
   // APB slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Handset state
   input wire power_on,
   input wire card_present,
   input wire multi_loop_fail,
   // Loop controls
   output wire loop_closed,
   output wire [3:0] loop_type,
   output wire loop_subch,
   output wire multi_loop,
   output wire [2:0] multi_mech,
   output wire [2:0] multi_slot,
   // Test console link and audio test port
   output wire test_console_link_active,
   output wire flow_resume_message,
   output wire [2:0] audio_function,
   output wire audio_port_active,
   // Acknowledgements toward the tester
   output wire ack_valid,
   output wire [7:0] ack_type,
   output wire [7:0] ack_result,
   output wire ack_has_result
);

   // ----------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------

   // Legacy test command set; the third-generation series stays unmapped.
   function legacy_type;
      input [7:0] mt;
      begin
         legacy_type = (mt[7:4] == 4'h0 || mt[7:4] == 4'h1 ||
                        mt[7:4] == 4'h2);
      end
   endfunction

   // Tested device codes that the audio test port knows.
   function audio_code_ok;
      input [2:0] code;
      begin
         audio_code_ok = (code == `AUDIO_NORMAL || code == `AUDIO_DECODER ||
                          code == `AUDIO_ENCODER || code == `AUDIO_ACOUSTIC);
      end
   endfunction

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------

   reg [1:0] ctrl_q;
   reg [1:0] msg_len_q;
   reg [31:0] prdata_q;
   reg [7:0] discard_cnt_q;
   reg loop_closed_q;
   reg [3:0] loop_type_q;
   reg loop_subch_q;
   reg multi_loop_q;
   reg [2:0] multi_mech_q;
   reg [2:0] multi_slot_q;
   reg multi_err_q;
   reg open_ack_req_q;
   reg console_q;
   reg resume_sent_q;
   reg resume_pulse_q;
   reg power_q;
   reg card_q;
   reg [2:0] audio_q;
   reg ack_valid_q;
   reg [7:0] ack_type_q;
   reg [7:0] ack_result_q;
   reg ack_has_result_q;

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------

   wire setup = psel && !penable;
   wire access = psel && penable;
   wire addr_ok = (paddr == `OFS_CTRL) || (paddr == `OFS_MSG_LEN) ||
                  (paddr == `OFS_MSG_DATA) || (paddr == `OFS_LOOP_STAT) ||
                  (paddr == `OFS_ACK) || (paddr == `OFS_DISCARD_CNT);
   wire wr = access && pwrite && addr_ok;
   wire msg_wr = wr && (paddr == `OFS_MSG_DATA);
   wire ack_clr = wr && (paddr == `OFS_ACK) && pwdata[`ACK_VALID_BIT];

   // Zero wait states; read data is captured in the setup cycle.
   assign pready = 1'b1;
   assign pslverr = access && !addr_ok;
   assign prdata = prdata_q;

   // Status word shared by the status register and its read path.
   wire [31:0] loop_stat = {12'h000, open_ack_req_q, audio_q,
                            resume_sent_q, console_q, multi_err_q,
                            multi_slot_q, multi_mech_q, multi_loop_q,
                            loop_subch_q, loop_type_q, loop_closed_q};

   // Read mux, sampled while the request is still in its setup cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
      end else if (setup && !pwrite) begin
         case (paddr)
            `OFS_CTRL: prdata_q <= {30'h00000000, ctrl_q};
            `OFS_MSG_LEN: prdata_q <= {30'h00000000, msg_len_q};
            `OFS_LOOP_STAT: prdata_q <= loop_stat;
            `OFS_ACK: prdata_q <= {ack_valid_q, 14'h0000, ack_has_result_q,
                                   ack_result_q, ack_type_q};
            `OFS_DISCARD_CNT: prdata_q <= {24'h000000, discard_cnt_q};
            default: prdata_q <= 32'h00000000;
         endcase
      end
   end

   // Plain control registers.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `CTRL_RESET;
         msg_len_q <= 2'h0;
      end else if (wr && paddr == `OFS_CTRL) begin
         ctrl_q <= pwdata[1:0];
      end else if (wr && paddr == `OFS_MSG_LEN) begin
         msg_len_q <= pwdata[1:0];
      end
   end

   // ----------------------------------------------------------------------
   // Message decode
   // ----------------------------------------------------------------------

   wire [3:0] proto = pwdata[3:0];
   wire [3:0] skip = pwdata[7:4];
   wire [7:0] mtype = pwdata[15:8];
   wire [7:0] oct3 = pwdata[23:16];

   wire [3:0] tr_type;
   wire tr_subch;
   wire ms_ok;
   wire [3:0] ms_type;
   wire [1:0] ms_coding;
   wire [2:0] ms_mech;
   wire [2:0] ms_slot;

   loop_field_decode u_fields (
      .subch_octet(oct3),
      .multi_octet(oct3),
      .traffic_type(tr_type),
      .traffic_subch(tr_subch),
      .multi_ok(ms_ok),
      .multi_type(ms_type),
      .multi_coding(ms_coding),
      .multi_mech(ms_mech),
      .multi_slot(ms_slot)
   );

   // A message is only looked at with the right header and decoding on.
   wire hdr_ok = (proto == `PROTO_TEST)
                 && (skip == `SKIP_NONE)
                 && legacy_type(mtype) && ctrl_q[`CTRL_DECODE_EN];

   // The open loop octet is optional; when present it must be well formed.
   wire open_octet_ok = (msg_len_q == 2'h0) ||
                        (oct3[7:4] == `OPEN_ACK_IEI &&
                         oct3[3:0] == `OPEN_ACK_VALUE);

   // Command strobes; close, open, multi-slot close and audio add their own length or field checks.
   wire do_close = msg_wr && hdr_ok && mtype == `MT_CLOSE_TRAFFIC &&
                   msg_len_q != 2'h0;
   wire do_open = msg_wr && hdr_ok && mtype == `MT_OPEN_LOOP &&
                  open_octet_ok;
   wire do_multi = msg_wr && hdr_ok && mtype == `MT_CLOSE_MULTI &&
                   msg_len_q != 2'h0 && ms_ok;
   wire do_open_multi = msg_wr && hdr_ok && mtype == `MT_OPEN_MULTI;
   wire do_act = msg_wr && hdr_ok && mtype == `MT_CONSOLE_ACT;
   wire do_deact = msg_wr && hdr_ok && mtype == `MT_CONSOLE_DEACT;
   wire do_audio = msg_wr && hdr_ok && mtype == `MT_AUDIO_TEST &&
                   msg_len_q != 2'h0 && audio_code_ok(oct3[2:0]);
   wire known = do_close || do_open || do_multi || do_open_multi ||
                do_act || do_deact || do_audio;

   // Counts every written message that was dropped, saturating at the top.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         discard_cnt_q <= 8'h00;
      end else if (msg_wr && !known && discard_cnt_q != 8'hff) begin
         discard_cnt_q <= discard_cnt_q + 8'h01;
      end
   end

   // ----------------------------------------------------------------------
   // Loop state
   // ----------------------------------------------------------------------

   // A failed multi-slot close leaves any existing loop as it was.
   wire multi_closes = do_multi && !multi_loop_fail;

   // Close commands overwrite the loop; open commands clear it.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_closed_q <= 1'b0;
         loop_type_q <= `LOOP_NONE;
         loop_subch_q <= 1'b0;
         multi_loop_q <= 1'b0;
         multi_mech_q <= `MECH_ONE;
         multi_slot_q <= 3'h0;
      end else if (do_close) begin
         loop_closed_q <= 1'b1;
         loop_type_q <= tr_type;
         loop_subch_q <= tr_subch;
         multi_loop_q <= 1'b0;
         multi_mech_q <= `MECH_ONE;
         multi_slot_q <= 3'h0;
      end else if (multi_closes) begin
         loop_closed_q <= 1'b1;
         loop_type_q <= ms_type;
         loop_subch_q <= 1'b0;
         multi_loop_q <= 1'b1;
         multi_mech_q <= ms_mech;
         // Slot number only means something for mechanism 1.
         multi_slot_q <= (ms_mech == `MECH_ONE) ? ms_slot : 3'h0;
      end else if (do_open || do_open_multi) begin
         loop_closed_q <= 1'b0;
         loop_type_q <= `LOOP_NONE;
         loop_subch_q <= 1'b0;
         multi_loop_q <= 1'b0;
         multi_mech_q <= `MECH_ONE;
         multi_slot_q <= 3'h0;
      end
   end

   // Result of the last multi-slot close and the open loop request flag.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         multi_err_q <= 1'b0;
         open_ack_req_q <= 1'b0;
      end else begin
         if (do_multi) begin
            multi_err_q <= multi_loop_fail;
         end
         if (do_open) begin
            open_ack_req_q <= (msg_len_q != 2'h0);
         end
      end
   end

   // ----------------------------------------------------------------------
   // Test console link
   // ----------------------------------------------------------------------

   // Power and card pins are synchronous; edges come from one-cycle history.
   wire power_rise = power_on && !power_q;
   wire card_rise = card_present && !card_q;
   wire console_off = !power_on || !card_present || do_deact;
   wire console_on = card_present && power_on &&
                     (power_rise || card_rise || do_act);

   // Deactivation wins, so a removed card can never leave the link on.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_q <= 1'b0;
         card_q <= 1'b0;
         console_q <= 1'b0;
      end else begin
         power_q <= power_on;
         card_q <= card_present;
         if (console_off) begin
            console_q <= 1'b0;
         end else if (console_on) begin
            console_q <= 1'b1;
         end
      end
   end

   // One flow-resume pulse per activation; no flow-stop is ever produced.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resume_sent_q <= 1'b0;
         resume_pulse_q <= 1'b0;
      end else begin
         resume_pulse_q <= 1'b0;
         if (!console_q) begin
            resume_sent_q <= 1'b0;
         end else if (!resume_sent_q && ctrl_q[`CTRL_CONSOLE_READY]) begin
            resume_sent_q <= 1'b1;
            resume_pulse_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Audio test port
   // ----------------------------------------------------------------------

   // A new function simply replaces the running one, with no stop between.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         audio_q <= `AUDIO_NORMAL;
      end else if (do_audio) begin
         audio_q <= oct3[2:0];
      end
   end

   // ----------------------------------------------------------------------
   // Acknowledgements
   // ----------------------------------------------------------------------

   // An acknowledgement raised in the cycle of a clear survives the clear.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_valid_q <= 1'b0;
         ack_type_q <= 8'h00;
         ack_result_q <= 8'h00;
         ack_has_result_q <= 1'b0;
      end else if (do_close) begin
         ack_valid_q <= 1'b1;
         ack_type_q <= `MT_CLOSE_TRAFFIC_ACK;
         ack_result_q <= 8'h00;
         ack_has_result_q <= 1'b0;
      end else if (do_multi) begin
         ack_valid_q <= 1'b1;
         ack_type_q <= `MT_CLOSE_MULTI_ACK;
         ack_result_q <= {2'b00, ms_coding, ms_mech, multi_loop_fail};
         ack_has_result_q <= 1'b1;
      end else if (do_open_multi) begin
         ack_valid_q <= 1'b1;
         ack_type_q <= `MT_OPEN_MULTI_ACK;
         ack_result_q <= 8'h00;
         ack_has_result_q <= 1'b0;
      end else if (do_act) begin
         ack_valid_q <= 1'b1;
         ack_type_q <= `MT_CONSOLE_ACT_ACK;
         ack_result_q <= 8'h00;
         ack_has_result_q <= 1'b0;
      end else if (ack_clr) begin
         ack_valid_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------

   assign loop_closed = loop_closed_q;
   assign loop_type = loop_type_q;
   assign loop_subch = loop_subch_q;
   assign multi_loop = multi_loop_q;
   assign multi_mech = multi_mech_q;
   assign multi_slot = multi_slot_q;
   assign test_console_link_active = console_q;
   assign flow_resume_message = resume_pulse_q;
   assign audio_function = audio_q;
   assign audio_port_active = (audio_q != `AUDIO_NORMAL);
   assign ack_valid = ack_valid_q;
   assign ack_type = ack_type_q;
   assign ack_result = ack_result_q;
   assign ack_has_result = ack_has_result_q;

endmodule

//--- test/test_loop_checker_sva.sv
// Checker for the port behaviour of the test loop command decoder.
module test_loop_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Handset state and loop controls
   input wire logic card_present,
   input wire logic loop_closed,
   input wire logic [3:0] loop_type,
   input wire logic multi_loop,
   input wire logic [2:0] multi_mech,
   input wire logic [2:0] multi_slot,
   // Console, audio and acknowledgements
   input wire logic test_console_link_active,
   input wire logic flow_resume_message,
   input wire logic [2:0] audio_function,
   input wire logic ack_valid,
   input wire logic [7:0] ack_type,
   input wire logic ack_has_result
);
   timeunit 1ns;
   timeprecision 1ps;
   // One clock domain, so one default clocking and disable serve all.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // The open multi-slot command is answered too, so its type is legal.
   property p_code;
      ack_valid |-> ack_type inside {8'h01, 8'h0d, 8'h21, 8'h23};
   endproperty
   a_code: assert property (p_code)
      else $error("unexpected acknowledgement type");
   property p_res; ack_valid |-> ack_has_result == (ack_type == 8'h21); endproperty
   a_res: assert property (p_res)
      else $error("result octet presence wrong");
   property p_once; flow_resume_message |=> !flow_resume_message; endproperty
   a_once: assert property (p_once)
      else $error("flow resume longer than one cycle");
   property p_act; flow_resume_message |-> $past(test_console_link_active); endproperty
   a_act: assert property (p_act)
      else $error("flow resume without active console");
   property p_card; !card_present |=> !test_console_link_active; endproperty
   a_card: assert property (p_card)
      else $error("console active without test card");
   property p_slot; multi_mech != 3'h0 |-> multi_slot == 3'h0; endproperty
   a_slot: assert property (p_slot)
      else $error("timeslot used with mechanism 2");
   property p_multi; multi_loop |-> loop_type inside {4'h7, 4'h8}; endproperty
   a_multi: assert property (p_multi)
      else $error("multi-slot loop of wrong type");
   property p_type; loop_closed |-> loop_type inside {[4'h1:4'h8]}; endproperty
   a_type: assert property (p_type)
      else $error("closed loop without a type");
   property p_aud; audio_function inside {3'h0, 3'h1, 3'h2, 3'h4}; endproperty
   a_aud: assert property (p_aud)
      else $error("reserved audio function");
   c_resume: cover property (flow_resume_message);
   c_multi: cover property (multi_loop);
   c_cack: cover property (ack_valid && ack_type == 8'h0d);
endmodule

//--- test/tester_model.sv
// Tester model: APB master that frames test-control messages.
module tester_model (
   // APB master side
   input wire logic pclk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // One transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // Length first, then the header word; spare octet bits go as zero.
   task automatic msg(input logic [3:0] pd, input logic [3:0] sk,
      input logic [7:0] mt, input logic [7:0] oc, input logic [1:0] len);
      logic [31:0] r;
      logic e;
      apb(1'b1, 8'h04, {30'h0, len}, r, e);
      apb(1'b1, 8'h08, {8'h00, oc, mt, sk, pd}, r, e);
   endtask
endmodule

//--- test/test_loop_command_decoder_tb.sv
// Self-checking bench for the test loop command decoder.
module test_loop_command_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, f;
   logic power_on, card_present, multi_loop_fail, loop_closed, loop_subch;
   logic multi_loop, ack_valid, ack_has_result, audio_port_active;
   logic test_console_link_active, flow_resume_message;
   logic [7:0] paddr, ack_type, ack_result, o;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] loop_type;
   logic [2:0] multi_mech, multi_slot, audio_function;
   integer bad_count = 0, num_checks = 0, seed = 32'hd9c3, pulses = 0;
   integer e_type = 0, e_disc = 0, i;
   test_loop_command_decoder i_test_loop_command_decoder (.*);
   tester_model tester (.*);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Counts resume pulses so repeats are caught.
   always @(posedge pclk) if (flow_resume_message === 1'b1) pulses++;
   task automatic check(input string n, input logic [31:0] s, x);
      num_checks++;
      if (s !== x) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Clears the ack, sends one message, waits for settled outputs.
   task automatic raw(input logic [3:0] pd, sk, input logic [7:0] mt, oc,
      input logic [1:0] len);
      tester.apb(1'b1, 8'h10, 32'h8000_0000, rd, err);
      tester.msg(pd, sk, mt, oc, len);
      @(negedge pclk);
   endtask
   // Loop type expected from a sub-channel octet.
   function automatic integer trf(input logic [7:0] v);
      if (v[4:3] != 2'b00) return 3 + v[4:3];
      if (v[2]) return 3;
      return v[1] ? 2 : 1;
   endfunction
   initial begin
      {presetn, power_on, card_present, multi_loop_fail} = 4'b0100;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      tester.apb(1'b0, 8'h00, 32'h0, rd, err);
      check("ctrl", rd, 32'h1);
      tester.apb(1'b0, 8'h18, 32'h0, rd, err);
      check("unmapped", rd, 32'h0);
      check("slverr", err, 1'b1);
      for (i = 0; i < 12; i++) begin
         o = $random(seed) & 8'h1f;
         raw(4'hf, 4'h0, 8'h00, o, 2'd1);
         e_type = trf(o);
         check("ttype", loop_type, e_type);
         check("subch", loop_subch, o[0]);
         check("tack", {ack_valid, ack_has_result, ack_type}, 10'h201);
      end
      $display("traffic loop test done");
      for (i = 0; i < 16; i++) begin
         f = $random(seed);
         o = {$random(seed) % 8, 1'b0, i[3:2], i[1:0]};
         @(posedge pclk) multi_loop_fail <= f;
         raw(4'hf, 4'h0, 8'h20, o, 2'd1);
         if (i[1] || i[3]) e_disc++;
         else begin
            check("mack", {ack_type, ack_result}, {8'h21, 2'b00, o[1:0],
               o[4:2], f});
            if (!f) e_type = 7 + i[0];
            if (!f) check("mslot", {multi_loop, multi_mech, multi_slot},
               {1'b1, o[4:2], i[2] ? 3'h0 : o[7:5]});
         end
         check("mvalid", ack_valid, !(i[1] || i[3]));
         check("mtype", loop_type, e_type);
      end
      $display("multi-slot loop test done");
      for (i = 0; i < 5; i++) begin
         tester.apb(1'b1, 8'h00, {31'h0, i != 4}, rd, err);
         raw(i == 0 ? 4'he : 4'hf, {3'h0, i == 1}, i == 2 ? 8'h40 : 8'h00,
            8'h00, {1'b0, i != 3});
         e_disc++;
         check("refused", {ack_valid, loop_type}, e_type);
      end
      tester.apb(1'b1, 8'h00, 32'h1, rd, err);
      raw(4'hf, 4'h0, 8'h06, 8'h81, 2'd1);
      check("open", {ack_valid, loop_closed}, 2'b00);
      raw(4'hf, 4'h0, 8'h22, 8'h00, 2'd0);
      check("omulti", {ack_valid, ack_type, loop_closed},
         {1'b1, 8'h23, 1'b0});
      raw(4'hf, 4'h0, 8'h06, 8'h82, 2'd1);
      e_disc++;
      $display("refusal and open loop test done");
      raw(4'hf, 4'h0, 8'h0c, 8'h00, 2'd0);
      check("nocard", {ack_valid, ack_type, test_console_link_active},
         10'h21a);
      tester.apb(1'b1, 8'h00, 32'h3, rd, err);
      @(posedge pclk) card_present <= 1'b1;
      repeat (6) @(posedge pclk);
      check("insert", {test_console_link_active, pulses[30:0]},
         {1'b1, 31'd1});
      raw(4'hf, 4'h0, 8'h10, 8'h00, 2'd0);
      check("deact", {ack_valid, test_console_link_active}, 2'b00);
      raw(4'hf, 4'h0, 8'h0c, 8'h00, 2'd0);
      repeat (6) @(posedge pclk);
      check("react", {test_console_link_active, pulses[30:0]},
         {1'b1, 31'd2});
      @(posedge pclk) card_present <= 1'b0;
      repeat (3) @(posedge pclk);
      check("remove", {test_console_link_active, pulses[30:0]},
         {1'b0, 31'd2});
      $display("console link test done");
      raw(4'hf, 4'h0, 8'h14, 8'h01, 2'd1);
      raw(4'hf, 4'h0, 8'h14, 8'h02, 2'd1);
      check("audio", audio_function, 3'h2);
      check("audport", audio_port_active, 1'b1);
      raw(4'hf, 4'h0, 8'h14, 8'h03, 2'd1);
      e_disc++;
      check("audkeep", audio_function, 3'h2);
      tester.apb(1'b0, 8'h14, 32'h0, rd, err);
      check("discards", rd, e_disc);
      $display("audio test done");
      complete_run();
   end
   initial begin
      #200us;
      bad_count++;
      complete_run();
   end
endmodule
bind test_loop_command_decoder test_loop_checker u_chk (.*);
